/* inc/pcr_pkg.sv */
`default_nettype none
package pcr_pkg;
    // register port widths
    localparam int PCR_ADDR_W = 16;
    localparam int PCR_DATA_W = 16;
    localparam int PCR_STRENGTH_W = 4;

    // word offsets of the eight pad control registers
    localparam logic [PCR_ADDR_W-1:0] PCR_SERIAL_OUT_OFS = 16'h0281;
    localparam logic [PCR_ADDR_W-1:0] PCR_SLAVE_SELECT_OFS = 16'h0282;
    localparam logic [PCR_ADDR_W-1:0] PCR_SERIAL_IN_OFS = 16'h0283;
    localparam logic [PCR_ADDR_W-1:0] PCR_ADDRESS_BIT15_OFS = 16'h0284;
    localparam logic [PCR_ADDR_W-1:0] PCR_FAULT_INDICATOR_OFS = 16'h0285;
    localparam logic [PCR_ADDR_W-1:0] PCR_FRAME_SYNC_OFS = 16'h0286;
    localparam logic [PCR_ADDR_W-1:0] PCR_CONVERSION_TRIGGER_OFS = 16'h0287;
    localparam logic [PCR_ADDR_W-1:0] PCR_SAMPLE_CLOCK_OFS = 16'h0288;

    // reset values: pull-down pads come up released, pull-up pads engaged
    localparam logic [PCR_DATA_W-1:0] PCR_RESET_PULL_OFF = 16'h0000;
    localparam logic [PCR_DATA_W-1:0] PCR_RESET_PULL_ON = 16'h0004;

    // field layout; bits above the pull bit are reserved
    localparam int PCR_PULL_BIT = 2;
    localparam int PCR_DRIVE_LSB = 0;
    localparam int PCR_DRIVE_MSB = 1;
    localparam logic [PCR_DATA_W-1:0] PCR_FIELD_MASK = 16'h0007;
    localparam logic [PCR_DATA_W-1:0] PCR_READ_IDLE = 16'h0000;

    // drive strength codes
    typedef enum logic [1:0] {
        PCR_DRV_LOWEST = 2'h0,
        PCR_DRV_LOW = 2'h1,
        PCR_DRV_HIGH = 2'h2,
        PCR_DRV_HIGHEST = 2'h3
    } pcr_drive_t;

    // one-hot strength selects, bit 0 lowest up to bit 3 highest
    localparam logic [PCR_STRENGTH_W-1:0] PCR_SEL_LOWEST = 4'h1;
    localparam logic [PCR_STRENGTH_W-1:0] PCR_SEL_LOW = 4'h2;
    localparam logic [PCR_STRENGTH_W-1:0] PCR_SEL_HIGH = 4'h4;
    localparam logic [PCR_STRENGTH_W-1:0] PCR_SEL_HIGHEST = 4'h8;
endpackage : pcr_pkg
`default_nettype wire

/* hw/pcr_pad_reg.sv */
`timescale 1ns/1ns
`default_nettype none
module pcr_pad_reg #(
    parameter logic [pcr_pkg::PCR_DATA_W-1:0] RESET_VALUE = pcr_pkg::PCR_RESET_PULL_OFF
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [pcr_pkg::PCR_DATA_W-1:0] wdata_in,
    output logic pull_en_out,
    output pcr_pkg::pcr_drive_t drive_code_out,
    output logic [pcr_pkg::PCR_DATA_W-1:0] rdata_out
);
    import pcr_pkg::*;

    logic [PCR_DATA_W-1:0] field;

    // only pull and drive bits are stored, so reserved bits cannot stick
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            field <= RESET_VALUE & PCR_FIELD_MASK;
        end else if (wr_en_in) begin
            field <= wdata_in & PCR_FIELD_MASK;
        end
    end

    // 0 releases the pull resistor, 1 engages it
    assign pull_en_out = field[PCR_PULL_BIT];
    assign drive_code_out = pcr_drive_t'(field[PCR_DRIVE_MSB:PCR_DRIVE_LSB]);
    assign rdata_out = field;
endmodule : pcr_pad_reg
`default_nettype wire

/* hw/pcr_drive_decode.sv */
`timescale 1ns/1ns
`default_nettype none
module pcr_drive_decode (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire pcr_pkg::pcr_drive_t code_in,
    output logic [pcr_pkg::PCR_STRENGTH_W-1:0] strength_out
);
    import pcr_pkg::*;

    logic [PCR_STRENGTH_W-1:0] next_strength;

    // code to one-hot pad strength leg select
    always_comb begin
        case (code_in)
            PCR_DRV_LOWEST: next_strength = PCR_SEL_LOWEST;
            PCR_DRV_LOW: next_strength = PCR_SEL_LOW;
            PCR_DRV_HIGH: next_strength = PCR_SEL_HIGH;
            default: next_strength = PCR_SEL_HIGHEST;
        endcase
    end

    // registered so the pad sees a glitch-free select
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            strength_out <= PCR_SEL_LOWEST;
        end else begin
            strength_out <= next_strength;
        end
    end
endmodule : pcr_drive_decode
`default_nettype wire

/* hw/pcr_pad_ctrl_bank.sv */
// What this block does
// - serial-out pad register at 0x281, resets 0x0000, bit 2 pull-down, bits 1:0 drive.
// - drive code 00 lowest, 01 low, 10 high, 11 highest strength.
// - pull bit 2 written 0 disables the pull resistor, 1 enables it.
// - slave-select pad register at 0x282, resets 0x0004, pull-up on after reset.
// - serial-in pad register at 0x283, resets 0x0000, bit 2 pull-down, drive bits.
// - address-bit-15 pad register at 0x284, resets 0x0000, pull-down and drive.
// - in parallel mode address-bit-15 drive also sets parallel data bit 6.
// - fault pad register at 0x285, resets 0x0004, pull-up on, drive bits.
// - frame-sync pad register at 0x286, resets 0x0000, pull-down and drive bits.
// - in parallel mode frame-sync drive also sets parallel data bit 7.
// - conversion-trigger pad register at 0x287, resets 0x0004, pull-up on, drive bits.
// - sample-clock pad register at 0x288, resets 0x0000, pull-down and drive bits.
`timescale 1ns/1ns
`default_nettype none
module pcr_pad_ctrl_bank (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic [pcr_pkg::PCR_ADDR_W-1:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [pcr_pkg::PCR_DATA_W-1:0] REG_WDATA_IN,
    output logic [pcr_pkg::PCR_DATA_W-1:0] REG_RDATA_OUT,
    output logic REG_ACK_OUT,
    output logic REG_ERR_OUT,
    input wire logic PARALLEL_PORT_MODE_IN,
    output logic SERIAL_OUT_PULL_EN_OUT,
    output logic [pcr_pkg::PCR_STRENGTH_W-1:0] SERIAL_OUT_DRIVE_OUT,
    output logic SLAVE_SELECT_PULL_EN_OUT,
    output logic [pcr_pkg::PCR_STRENGTH_W-1:0] SLAVE_SELECT_DRIVE_OUT,
    output logic SERIAL_IN_PULL_EN_OUT,
    output logic [pcr_pkg::PCR_STRENGTH_W-1:0] SERIAL_IN_DRIVE_OUT,
    output logic ADDRESS_BIT15_PULL_EN_OUT,
    output logic [pcr_pkg::PCR_STRENGTH_W-1:0] ADDRESS_BIT15_DRIVE_OUT,
    output logic FAULT_INDICATOR_PULL_EN_OUT,
    output logic [pcr_pkg::PCR_STRENGTH_W-1:0] FAULT_INDICATOR_DRIVE_OUT,
    output logic FRAME_SYNC_PULL_EN_OUT,
    output logic [pcr_pkg::PCR_STRENGTH_W-1:0] FRAME_SYNC_DRIVE_OUT,
    output logic CONVERSION_TRIGGER_PULL_EN_OUT,
    output logic [pcr_pkg::PCR_STRENGTH_W-1:0] CONVERSION_TRIGGER_DRIVE_OUT,
    output logic SAMPLE_CLOCK_PULL_EN_OUT,
    output logic [pcr_pkg::PCR_STRENGTH_W-1:0] SAMPLE_CLOCK_DRIVE_OUT,
    output logic [pcr_pkg::PCR_STRENGTH_W-1:0] PARALLEL_DATA_BIT6_DRIVE_OUT,
    output logic [pcr_pkg::PCR_STRENGTH_W-1:0] PARALLEL_DATA_BIT7_DRIVE_OUT
);
    import pcr_pkg::*;

    // address decode results
    logic sel_serial_out;
    logic sel_slave_select;
    logic sel_serial_in;
    logic sel_address_bit15;
    logic sel_fault_indicator;
    logic sel_frame_sync;
    logic sel_conversion_trigger;
    logic sel_sample_clock;
    logic sel_none;

    // register readback values
    logic [PCR_DATA_W-1:0] rd_serial_out;
    logic [PCR_DATA_W-1:0] rd_slave_select;
    logic [PCR_DATA_W-1:0] rd_serial_in;
    logic [PCR_DATA_W-1:0] rd_address_bit15;
    logic [PCR_DATA_W-1:0] rd_fault_indicator;
    logic [PCR_DATA_W-1:0] rd_frame_sync;
    logic [PCR_DATA_W-1:0] rd_conversion_trigger;
    logic [PCR_DATA_W-1:0] rd_sample_clock;
    logic [PCR_DATA_W-1:0] next_rdata;

    // drive codes: stored per pad, muxed for the parallel data legs
    pcr_drive_t serial_out_drive_code;
    pcr_drive_t slave_select_drive_code;
    pcr_drive_t serial_in_drive_code;
    pcr_drive_t address_bit15_drive_code;
    pcr_drive_t fault_indicator_drive_code;
    pcr_drive_t frame_sync_drive_code;
    pcr_drive_t conversion_trigger_drive_code;
    pcr_drive_t sample_clock_drive_code;
    pcr_drive_t parallel_data_bit6_code;
    pcr_drive_t parallel_data_bit7_code;

    // pull enables straight from the stored field
    logic address_bit15_pull_en;
    logic frame_sync_pull_en;

    // decode the word offset; anything else is unmapped
    always_comb begin
        sel_serial_out = 1'b0;
        sel_slave_select = 1'b0;
        sel_serial_in = 1'b0;
        sel_address_bit15 = 1'b0;
        sel_fault_indicator = 1'b0;
        sel_frame_sync = 1'b0;
        sel_conversion_trigger = 1'b0;
        sel_sample_clock = 1'b0;
        sel_none = 1'b0;
        if (REG_ADDR_IN == PCR_SERIAL_OUT_OFS) begin
            sel_serial_out = 1'b1;
        end else if (REG_ADDR_IN == PCR_SLAVE_SELECT_OFS) begin
            sel_slave_select = 1'b1;
        end else if (REG_ADDR_IN == PCR_SERIAL_IN_OFS) begin
            sel_serial_in = 1'b1;
        end else if (REG_ADDR_IN == PCR_ADDRESS_BIT15_OFS) begin
            sel_address_bit15 = 1'b1;
        end else if (REG_ADDR_IN == PCR_FAULT_INDICATOR_OFS) begin
            sel_fault_indicator = 1'b1;
        end else if (REG_ADDR_IN == PCR_FRAME_SYNC_OFS) begin
            sel_frame_sync = 1'b1;
        end else if (REG_ADDR_IN == PCR_CONVERSION_TRIGGER_OFS) begin
            sel_conversion_trigger = 1'b1;
        end else if (REG_ADDR_IN == PCR_SAMPLE_CLOCK_OFS) begin
            sel_sample_clock = 1'b1;
        end else begin
            sel_none = 1'b1;
        end
    end

    // serial-out pad, pull-down, released at reset
    pcr_pad_reg #(
        .RESET_VALUE(PCR_RESET_PULL_OFF)
    ) u_serial_out (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .wr_en_in(REG_WR_IN && sel_serial_out),
        .wdata_in(REG_WDATA_IN),
        .pull_en_out(SERIAL_OUT_PULL_EN_OUT),
        .drive_code_out(serial_out_drive_code),
        .rdata_out(rd_serial_out)
    );

    // slave-select pad, pull-up engaged at reset so the select idles high
    pcr_pad_reg #(
        .RESET_VALUE(PCR_RESET_PULL_ON)
    ) u_slave_select (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .wr_en_in(REG_WR_IN && sel_slave_select),
        .wdata_in(REG_WDATA_IN),
        .pull_en_out(SLAVE_SELECT_PULL_EN_OUT),
        .drive_code_out(slave_select_drive_code),
        .rdata_out(rd_slave_select)
    );

    // serial-in pad, pull-down
    pcr_pad_reg #(
        .RESET_VALUE(PCR_RESET_PULL_OFF)
    ) u_serial_in (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .wr_en_in(REG_WR_IN && sel_serial_in),
        .wdata_in(REG_WDATA_IN),
        .pull_en_out(SERIAL_IN_PULL_EN_OUT),
        .drive_code_out(serial_in_drive_code),
        .rdata_out(rd_serial_in)
    );

    // address-bit-15 pad, shared with parallel data bit 6
    pcr_pad_reg #(
        .RESET_VALUE(PCR_RESET_PULL_OFF)
    ) u_address_bit15 (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .wr_en_in(REG_WR_IN && sel_address_bit15),
        .wdata_in(REG_WDATA_IN),
        .pull_en_out(address_bit15_pull_en),
        .drive_code_out(address_bit15_drive_code),
        .rdata_out(rd_address_bit15)
    );

    // fault indicator pad, pull-up engaged at reset
    pcr_pad_reg #(
        .RESET_VALUE(PCR_RESET_PULL_ON)
    ) u_fault_indicator (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .wr_en_in(REG_WR_IN && sel_fault_indicator),
        .wdata_in(REG_WDATA_IN),
        .pull_en_out(FAULT_INDICATOR_PULL_EN_OUT),
        .drive_code_out(fault_indicator_drive_code),
        .rdata_out(rd_fault_indicator)
    );

    // frame-sync pad, shared with parallel data bit 7
    pcr_pad_reg #(
        .RESET_VALUE(PCR_RESET_PULL_OFF)
    ) u_frame_sync (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .wr_en_in(REG_WR_IN && sel_frame_sync),
        .wdata_in(REG_WDATA_IN),
        .pull_en_out(frame_sync_pull_en),
        .drive_code_out(frame_sync_drive_code),
        .rdata_out(rd_frame_sync)
    );

    // conversion trigger input pad, pull-up keeps it idle when undriven
    pcr_pad_reg #(
        .RESET_VALUE(PCR_RESET_PULL_ON)
    ) u_conversion_trigger (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .wr_en_in(REG_WR_IN && sel_conversion_trigger),
        .wdata_in(REG_WDATA_IN),
        .pull_en_out(CONVERSION_TRIGGER_PULL_EN_OUT),
        .drive_code_out(conversion_trigger_drive_code),
        .rdata_out(rd_conversion_trigger)
    );

    // sample-data clock pad, pull-down
    pcr_pad_reg #(
        .RESET_VALUE(PCR_RESET_PULL_OFF)
    ) u_sample_clock (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .wr_en_in(REG_WR_IN && sel_sample_clock),
        .wdata_in(REG_WDATA_IN),
        .pull_en_out(SAMPLE_CLOCK_PULL_EN_OUT),
        .drive_code_out(sample_clock_drive_code),
        .rdata_out(rd_sample_clock)
    );

    assign ADDRESS_BIT15_PULL_EN_OUT = address_bit15_pull_en;
    assign FRAME_SYNC_PULL_EN_OUT = frame_sync_pull_en;

    // shared pins: parallel data legs follow the pin's drive only in parallel mode,
    // otherwise they sit at the weakest setting to limit edge noise
    assign parallel_data_bit6_code = PARALLEL_PORT_MODE_IN ?
        address_bit15_drive_code : PCR_DRV_LOWEST;
    assign parallel_data_bit7_code = PARALLEL_PORT_MODE_IN ?
        frame_sync_drive_code : PCR_DRV_LOWEST;

    // strength decoders, one per pad leg
    pcr_drive_decode u_dec_serial_out (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .code_in(serial_out_drive_code),
        .strength_out(SERIAL_OUT_DRIVE_OUT)
    );

    pcr_drive_decode u_dec_slave_select (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .code_in(slave_select_drive_code),
        .strength_out(SLAVE_SELECT_DRIVE_OUT)
    );

    pcr_drive_decode u_dec_serial_in (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .code_in(serial_in_drive_code),
        .strength_out(SERIAL_IN_DRIVE_OUT)
    );

    pcr_drive_decode u_dec_address_bit15 (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .code_in(address_bit15_drive_code),
        .strength_out(ADDRESS_BIT15_DRIVE_OUT)
    );

    pcr_drive_decode u_dec_fault_indicator (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .code_in(fault_indicator_drive_code),
        .strength_out(FAULT_INDICATOR_DRIVE_OUT)
    );

    pcr_drive_decode u_dec_frame_sync (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .code_in(frame_sync_drive_code),
        .strength_out(FRAME_SYNC_DRIVE_OUT)
    );

    pcr_drive_decode u_dec_conversion_trigger (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .code_in(conversion_trigger_drive_code),
        .strength_out(CONVERSION_TRIGGER_DRIVE_OUT)
    );

    pcr_drive_decode u_dec_sample_clock (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .code_in(sample_clock_drive_code),
        .strength_out(SAMPLE_CLOCK_DRIVE_OUT)
    );

    pcr_drive_decode u_dec_parallel_bit6 (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .code_in(parallel_data_bit6_code),
        .strength_out(PARALLEL_DATA_BIT6_DRIVE_OUT)
    );

    pcr_drive_decode u_dec_parallel_bit7 (
        .clk_in(MCLK_IN),
        .rst_in(RST_IN),
        .code_in(parallel_data_bit7_code),
        .strength_out(PARALLEL_DATA_BIT7_DRIVE_OUT)
    );

    // readback mux; unmapped offsets read as zero
    always_comb begin
        next_rdata = PCR_READ_IDLE;
        if (sel_serial_out) begin
            next_rdata = rd_serial_out;
        end else if (sel_slave_select) begin
            next_rdata = rd_slave_select;
        end else if (sel_serial_in) begin
            next_rdata = rd_serial_in;
        end else if (sel_address_bit15) begin
            next_rdata = rd_address_bit15;
        end else if (sel_fault_indicator) begin
            next_rdata = rd_fault_indicator;
        end else if (sel_frame_sync) begin
            next_rdata = rd_frame_sync;
        end else if (sel_conversion_trigger) begin
            next_rdata = rd_conversion_trigger;
        end else if (sel_sample_clock) begin
            next_rdata = rd_sample_clock;
        end
    end

    // read data held until the next read; reserved bits forced low again
    // so a future field widening cannot leak stray bits
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= PCR_READ_IDLE;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT <= next_rdata & PCR_FIELD_MASK;
        end
    end

    // one-cycle acknowledge for any access, error flag for unmapped ones
    always_ff @(posedge MCLK_IN) begin
        if (RST_IN) begin
            REG_ACK_OUT <= 1'b0;
            REG_ERR_OUT <= 1'b0;
        end else begin
            REG_ACK_OUT <= REG_RD_IN || REG_WR_IN;
            REG_ERR_OUT <= (REG_RD_IN || REG_WR_IN) && sel_none;
        end
    end
endmodule : pcr_pad_ctrl_bank
`default_nettype wire

/* dv/pcr_pad_ctrl_bank_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module pcr_pad_ctrl_bank_asserts (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic [pcr_pkg::PCR_ADDR_W-1:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [pcr_pkg::PCR_DATA_W-1:0] REG_WDATA_IN,
    input wire logic [pcr_pkg::PCR_DATA_W-1:0] REG_RDATA_OUT,
    input wire logic REG_ACK_OUT,
    input wire logic REG_ERR_OUT,
    input wire logic PARALLEL_PORT_MODE_IN,
    input wire logic SLAVE_SELECT_PULL_EN_OUT,
    input wire logic ADDRESS_BIT15_PULL_EN_OUT,
    input wire logic [pcr_pkg::PCR_STRENGTH_W-1:0] ADDRESS_BIT15_DRIVE_OUT,
    input wire logic [pcr_pkg::PCR_STRENGTH_W-1:0] FRAME_SYNC_DRIVE_OUT,
    input wire logic [pcr_pkg::PCR_STRENGTH_W-1:0] PARALLEL_DATA_BIT6_DRIVE_OUT,
    input wire logic [pcr_pkg::PCR_STRENGTH_W-1:0] PARALLEL_DATA_BIT7_DRIVE_OUT
);
    import pcr_pkg::*;
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    // anything below 0x281 or above 0x288 is unmapped, so neighbours of the bank must flag
    logic unmapped;
    assign unmapped = (REG_ADDR_IN < PCR_SERIAL_OUT_OFS) || (REG_ADDR_IN > PCR_SAMPLE_CLOCK_OFS);

    ack_follows_access_a: assert property (1'b1 |=> REG_ACK_OUT == $past(REG_WR_IN || REG_RD_IN))
        else $error("ack does not follow access");
    err_on_unmapped_a: assert property ((REG_WR_IN || REG_RD_IN) && unmapped |=> REG_ERR_OUT && REG_ACK_OUT)
        else $error("no error on unmapped access");
    err_mapped_quiet_a: assert property ((REG_WR_IN || REG_RD_IN) && !unmapped |=> !REG_ERR_OUT)
        else $error("error on mapped access");
    reserved_read_zero_a: assert property (REG_ACK_OUT |-> REG_RDATA_OUT[15:3] == 13'h0000)
        else $error("reserved bits read nonzero");
    pull_write_a: assert property (REG_WR_IN && REG_ADDR_IN == 16'h0284 |=>
        ADDRESS_BIT15_PULL_EN_OUT == $past(REG_WDATA_IN[2]))
        else $error("pull enable not taken from bit 2");
    drive_decode_a: assert property (REG_WR_IN && REG_ADDR_IN == 16'h0286 |=> ##1
        FRAME_SYNC_DRIVE_OUT == (4'h1 << $past(REG_WDATA_IN[1:0], 2)))
        else $error("drive select does not match code");
    read_old_value_a: assert property (REG_RD_IN && REG_ADDR_IN == 16'h0284 |=>
        REG_RDATA_OUT[2] == $past(ADDRESS_BIT15_PULL_EN_OUT))
        else $error("read pull bit differs from register");
    bit6_share_a: assert property (1'b1 |=> PARALLEL_DATA_BIT6_DRIVE_OUT ==
        ($past(PARALLEL_PORT_MODE_IN) ? ADDRESS_BIT15_DRIVE_OUT : 4'h1))
        else $error("data bit 6 drive wrong");
    bit7_share_a: assert property (1'b1 |=> PARALLEL_DATA_BIT7_DRIVE_OUT ==
        ($past(PARALLEL_PORT_MODE_IN) ? FRAME_SYNC_DRIVE_OUT : 4'h1))
        else $error("data bit 7 drive wrong");
    reset_pulls_a: assert property ($fell(RST_IN) |-> SLAVE_SELECT_PULL_EN_OUT
        && !ADDRESS_BIT15_PULL_EN_OUT)
        else $error("pull enables wrong after reset");
endmodule : pcr_pad_ctrl_bank_asserts

bind pcr_pad_ctrl_bank pcr_pad_ctrl_bank_asserts u_chk (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_ACK_OUT(REG_ACK_OUT),
    .REG_ERR_OUT(REG_ERR_OUT), .PARALLEL_PORT_MODE_IN(PARALLEL_PORT_MODE_IN),
    .SLAVE_SELECT_PULL_EN_OUT(SLAVE_SELECT_PULL_EN_OUT),
    .ADDRESS_BIT15_PULL_EN_OUT(ADDRESS_BIT15_PULL_EN_OUT),
    .ADDRESS_BIT15_DRIVE_OUT(ADDRESS_BIT15_DRIVE_OUT),
    .FRAME_SYNC_DRIVE_OUT(FRAME_SYNC_DRIVE_OUT),
    .PARALLEL_DATA_BIT6_DRIVE_OUT(PARALLEL_DATA_BIT6_DRIVE_OUT),
    .PARALLEL_DATA_BIT7_DRIVE_OUT(PARALLEL_DATA_BIT7_DRIVE_OUT));
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pcr_pkg::*;
    // pads whose pull-up is engaged out of reset: slave select, fault, trigger
    localparam logic [7:0] PULL_UP_MAP = 8'h52;
    logic MCLK_IN;
    logic RST_IN;
    logic [15:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic reg_ack;
    logic reg_err;
    logic par_mode;
    logic [7:0] pull_v;
    logic [31:0] drv_v;
    logic [3:0] bit6_drv;
    logic [3:0] bit7_drv;
    int failures;
    int tests_run;
    int cycles = 0;

    // pads packed in offset order so index i is offset 0x281 + i
    pcr_pad_ctrl_bank dut (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN), .REG_ADDR_IN(reg_addr),
        .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_WDATA_IN(reg_wdata),
        .REG_RDATA_OUT(reg_rdata), .REG_ACK_OUT(reg_ack), .REG_ERR_OUT(reg_err),
        .PARALLEL_PORT_MODE_IN(par_mode),
        .SERIAL_OUT_PULL_EN_OUT(pull_v[0]), .SERIAL_OUT_DRIVE_OUT(drv_v[3:0]),
        .SLAVE_SELECT_PULL_EN_OUT(pull_v[1]), .SLAVE_SELECT_DRIVE_OUT(drv_v[7:4]),
        .SERIAL_IN_PULL_EN_OUT(pull_v[2]), .SERIAL_IN_DRIVE_OUT(drv_v[11:8]),
        .ADDRESS_BIT15_PULL_EN_OUT(pull_v[3]), .ADDRESS_BIT15_DRIVE_OUT(drv_v[15:12]),
        .FAULT_INDICATOR_PULL_EN_OUT(pull_v[4]), .FAULT_INDICATOR_DRIVE_OUT(drv_v[19:16]),
        .FRAME_SYNC_PULL_EN_OUT(pull_v[5]), .FRAME_SYNC_DRIVE_OUT(drv_v[23:20]),
        .CONVERSION_TRIGGER_PULL_EN_OUT(pull_v[6]),
        .CONVERSION_TRIGGER_DRIVE_OUT(drv_v[27:24]),
        .SAMPLE_CLOCK_PULL_EN_OUT(pull_v[7]), .SAMPLE_CLOCK_DRIVE_OUT(drv_v[31:28]),
        .PARALLEL_DATA_BIT6_DRIVE_OUT(bit6_drv), .PARALLEL_DATA_BIT7_DRIVE_OUT(bit7_drv));

    // clock, 100 ns period
    always #50 MCLK_IN = ~MCLK_IN;

    task automatic wrap_up;
        $display("mismatches %0d, comparisons %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // a hung handshake would otherwise run forever
    always @(posedge MCLK_IN) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // one access; the strobe stands for exactly one taking edge
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic e);
        @(posedge MCLK_IN);
        reg_wr <= wr;
        reg_rd <= ~wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge MCLK_IN);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        chk(reg_ack, 1'b1, "ack");
        q = reg_rdata;
        e = reg_err;
    endtask : acc

    task automatic do_reset;
        RST_IN <= 1'b1;
        repeat (5) @(posedge MCLK_IN);
        RST_IN <= 1'b0;
        @(posedge MCLK_IN);
    endtask : do_reset

    task automatic check_reset_state;
        logic [15:0] q;
        logic e;
        for (int i = 0; i < 8; i++) begin
            acc(1'b0, 16'h0281 + 16'(i), 16'h0000, q, e);
            chk(q, PULL_UP_MAP[i] ? 16'h0004 : 16'h0000, "reset value");
            chk(e, 1'b0, "err on mapped read");
        end
        chk(pull_v, PULL_UP_MAP, "reset pulls");
        chk(drv_v, 32'h11111111, "reset drive");
    endtask : check_reset_state

    // every code and both pull states through every pad, reserved bits set
    task automatic field_walk;
        logic [15:0] q;
        logic e;
        logic p;
        for (int i = 0; i < 8; i++) begin
            for (int c = 0; c < 4; c++) begin
                p = c[0] ^ i[0];
                acc(1'b1, 16'h0281 + 16'(i), {13'h1fff, p, 2'(c)}, q, e);
                acc(1'b0, 16'h0281 + 16'(i), 16'h0000, q, e);
                chk(q, {13'h0000, p, 2'(c)}, "readback");
                chk(pull_v[i], p, "pull enable");
                chk(drv_v[4*i +: 4], 4'h1 << c, "drive select");
            end
        end
    endtask : field_walk

    // neighbours just outside the bank must not alias into it
    task automatic unmapped_access;
        logic [15:0] q;
        logic e;
        for (int k = 0; k < 2; k++) begin
            acc(1'b1, k ? 16'h0289 : 16'h0280, 16'h0007, q, e);
            chk(e, 1'b1, "err on unmapped write");
            acc(1'b0, k ? 16'h0289 : 16'h0280, 16'h0000, q, e);
            chk({e, q}, 17'h10000, "unmapped read");
        end
        chk(pull_v, PULL_UP_MAP, "bank untouched");
        chk(drv_v, 32'h11111111, "drive untouched");
    endtask : unmapped_access

    task automatic parallel_share;
        logic [15:0] q;
        logic e;
        acc(1'b1, 16'h0284, 16'h0002, q, e);
        acc(1'b1, 16'h0286, 16'h0003, q, e);
        @(posedge MCLK_IN);
        #1;
        chk({bit7_drv, bit6_drv}, 8'h11, "serial mode data drive");
        // mode changes on an edge; the decoders see it one edge later
        @(posedge MCLK_IN);
        par_mode <= 1'b1;
        @(posedge MCLK_IN);
        #1;
        chk({bit7_drv, bit6_drv}, 8'h84, "parallel mode data drive");
        acc(1'b1, 16'h0284, 16'h0001, q, e);
        @(posedge MCLK_IN);
        #1;
        chk(bit6_drv, 4'h2, "bit 6 follows new code");
        @(posedge MCLK_IN);
        par_mode <= 1'b0;
        @(posedge MCLK_IN);
        #1;
        chk({bit7_drv, bit6_drv}, 8'h11, "back to lowest");
    endtask : parallel_share

    initial begin
        MCLK_IN = 1'b0;
        RST_IN = 1'b1;
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
        par_mode = 1'b0;
        failures = 0;
        tests_run = 0;
        do_reset();
        check_reset_state();
        field_walk();
        // mid-run reset is raised on an edge like every other input
        @(posedge MCLK_IN);
        do_reset();
        check_reset_state();
        unmapped_access();
        parallel_share();
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
